/* rtl/fml_regs.sv */
// Purpose: Status and control registers of the fast link mode
// Assumes: PHY and link inputs are on core_clk; por_rst is power-on
// Notes:   rst is the warm reset; sticky fields survive it when selected
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns

// Summary of operation
// [RULE1] Status bits 6:0 show negotiated fast rate; 0 inactive, 1/2 base.
// [RULE2] Rate status also codes 8, 16, 20, 25 and 32 GT/s.
// [RULE3] Negotiated rate status reads zero after reset.
// [RULE4] Status bit 7 sets when requested calibration finishes.
// [RULE5] Calibration done flag resets to zero.
// [RULE6] Control bits 6:0 select the lower fast rate: none, 8, 16.
// [RULE7] Lower rate select also takes 20, 25 and 32 GT/s.
// [RULE8] Software programs both selects with supported rates before entry.
// [RULE9] Control bits 14:8 select upper rate: none, 16, 20, 32.
// [RULE10] Both rate selects reset to zero.
// [RULE11] Writing one to control bit 7 requests calibration.
// [RULE12] Calibration runs only with link parked in L1, non-D0 state.
// [RULE13] Calibration start bit always reads zero.
// [RULE14] Writing one to bit 15 while zero starts entry at base rates.
// [RULE15] Software never requests entry at other rates or outside PCIe.
// [RULE16] Entry request bit resets to zero.
// [RULE17] With compliance set, control fields are sticky; else plain.
// [RULE18] Optional rate capability register is all reserved.
// [RULE19] Registers exist only when fast mode is supported.
// [RULE20] Status bits 31:8 are reserved and read zero.
// [RULE21] Software sets compliance bit 19 only for compliance tests.
// [RULE22] Sticky fields clear only on power-on reset.
module fml_regs
    import fml_pkg::*;
#(
    parameter bit FAST_MODE_SUPPORTED = 1'b1
)
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              por_rst,
    input  wire logic [ADDR_W-1:0] rd_addr,
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic              wr_en,
    input  wire logic [DATA_W-1:0] wr_data,
    output logic      [DATA_W-1:0] rd_data,
    input  wire logic [6:0]        phy_fast_rate,
    input  wire logic [6:0]        link_speed,
    input  wire logic              link_pcie_mode,
    input  wire logic              link_in_l1,
    input  wire logic              pm_non_d0,
    input  wire logic              phy_cal_ack,
    output logic                   phy_cal_run,
    output logic                   fast_entry_go,
    output logic      [6:0]        fast_rate_sel_low,
    output logic      [6:0]        fast_rate_sel_high,
    output logic      [6:0]        negotiated_fast_rate,
    output logic                   calib_done_flag,
    output logic                   compliance_sticky_select
);
    // All register state of the bank
    typedef struct packed
    {
        logic [6:0]        sel_lo;
        logic [6:0]        sel_hi;
        logic              ena;
        logic              comp;
        logic [6:0]        rate;
        logic              done;
        logic [DATA_W-1:0] rdata;
        logic              cal_req;
        logic              ent_req;
    } fml_regs_t;

    localparam fml_regs_t RST_ALL = '{
        sel_lo:  RST_RATE,
        sel_hi:  RST_RATE,
        ena:     1'b0,
        comp:    1'b0,
        rate:    RST_RATE,
        done:    1'b0,
        rdata:   RST_WORD,
        cal_req: 1'b0,
        ent_req: 1'b0
    };

    fml_regs_t s_q;
    fml_regs_t s_d;
    fml_ctl_if ctl ();
    logic      wr_ctl;
    logic      seq_rst;

    // Writes land only when the mode exists at all
    assign wr_ctl = wr_en && (wr_addr == OFS_CONTROL) &&
                    FAST_MODE_SUPPORTED; // RULE19

    // Warm reset spares a held calibration request under compliance
    assign seq_rst = por_rst || (rst && !s_q.comp); // RULE17

    // Next state of the bank
    always_comb
    begin
        s_d         = s_q;
        s_d.cal_req = 1'b0;
        s_d.ent_req = 1'b0;
        s_d.rdata   = RST_WORD;

        // Negotiated rate follows the PHY; odd codes are not taken
        if (fml_stat_ok(phy_fast_rate))
            s_d.rate = phy_fast_rate; // RULE1 RULE2

        if (wr_ctl)
        begin
            // Reserved select codes are dropped to keep the PHY sane
            if (fml_low_ok(wr_data[RATE_LSB +: RATE_W]))
                s_d.sel_lo = wr_data[RATE_LSB +: RATE_W]; // RULE6 RULE7
            if (fml_high_ok(wr_data[SEL_HI_LSB +: RATE_W]))
                s_d.sel_hi = wr_data[SEL_HI_LSB +: RATE_W]; // RULE9
            s_d.comp = wr_data[COMP_BIT];
            if (wr_data[CAL_BIT])
            begin
                s_d.cal_req = 1'b1; // RULE11
                s_d.done    = 1'b0;
            end
            // Only a rising write of the enable asks for entry
            if (wr_data[ENA_BIT] && !s_q.ena)
                s_d.ent_req = 1'b1; // RULE14
            s_d.ena = wr_data[ENA_BIT];
        end

        // Completion beats a clear in the same cycle
        if (ctl.cal_done)
            s_d.done = 1'b1; // RULE4

        // Read path, data valid in the following cycle only
        if (rd_en && FAST_MODE_SUPPORTED)
        begin
            if (rd_addr == OFS_STATUS)
            begin
                s_d.rdata[RATE_LSB +: RATE_W] = s_q.rate; // RULE20
                s_d.rdata[DONE_BIT]           = s_q.done;
            end
            else if (rd_addr == OFS_CONTROL)
            begin
                s_d.rdata[RATE_LSB +: RATE_W]   = s_q.sel_lo;
                s_d.rdata[CAL_BIT]              = 1'b0; // RULE13
                s_d.rdata[SEL_HI_LSB +: RATE_W] = s_q.sel_hi;
                s_d.rdata[ENA_BIT]              = s_q.ena;
                s_d.rdata[COMP_BIT]             = s_q.comp;
            end
            else if (rd_addr == OFS_OPT_CAP)
                s_d.rdata = RST_WORD; // RULE18
            else
                s_d.rdata = RST_WORD;
        end

        // Warm reset clears live state; sticky fields may ride through
        if (rst)
        begin
            s_d.rate    = RST_RATE; // RULE3
            s_d.done    = 1'b0; // RULE5
            s_d.rdata   = RST_WORD;
            s_d.cal_req = 1'b0;
            s_d.ent_req = 1'b0;
            if (!s_q.comp)
            begin
                s_d.sel_lo = RST_RATE; // RULE10
                s_d.sel_hi = RST_RATE;
                s_d.ena    = 1'b0; // RULE16
            end
        end

        // Power-on clears everything, the compliance bit too
        if (por_rst)
            s_d = RST_ALL; // RULE22
    end

    always_ff @(posedge core_clk)
        s_q <= s_d;

    assign ctl.cal_req = s_q.cal_req;
    assign ctl.ent_req = s_q.ent_req;

    // Calibration hold-off until the link is parked
    fml_cal_seq fml_cal_seq_inst
    (
        .core_clk    (core_clk),
        .seq_rst     (seq_rst),
        .link_in_l1  (link_in_l1),
        .pm_non_d0   (pm_non_d0),
        .phy_cal_ack (phy_cal_ack),
        .ctl         (ctl.cal)
    );

    // Entry gating on the current link rate
    fml_entry fml_entry_inst
    (
        .core_clk       (core_clk),
        .rst            (rst),
        .link_speed     (link_speed),
        .link_pcie_mode (link_pcie_mode),
        .ctl            (ctl.ent)
    );

    // Outputs, each a flop here or in a helper
    assign rd_data                  = s_q.rdata;
    assign phy_cal_run              = ctl.cal_run;
    assign fast_entry_go            = ctl.ent_go;
    assign fast_rate_sel_low        = s_q.sel_lo;
    assign fast_rate_sel_high       = s_q.sel_hi;
    assign negotiated_fast_rate     = s_q.rate;
    assign calib_done_flag          = s_q.done;
    assign compliance_sticky_select = s_q.comp;

    chk_rate_after_reset: assert property (@(posedge core_clk) // RULE3
        disable iff (por_rst) rst |=> negotiated_fast_rate == RST_RATE)
        else $error("negotiated rate not zero after reset");

    chk_done_after_reset: assert property (@(posedge core_clk) // RULE5
        disable iff (por_rst) rst |=> !calib_done_flag)
        else $error("calibration done not clear after reset");

    chk_done_on_finish: assert property (@(posedge core_clk) // RULE4
        disable iff (rst || por_rst)
        (fml_cal_seq_inst.s_q.st == FML_CAL_RUN) && phy_cal_ack
        |=> ##1 calib_done_flag)
        else $error("calibration finish did not set done flag");

    chk_cal_reads_zero: assert property (@(posedge core_clk) // RULE13
        disable iff (rst || por_rst)
        rd_en && rd_addr == OFS_CONTROL |=> !rd_data[CAL_BIT])
        else $error("calibration start bit read back as one");

    chk_status_rsvd_zero: assert property (@(posedge core_clk) // RULE20
        disable iff (rst || por_rst)
        rd_en && rd_addr == OFS_STATUS
        |=> rd_data[DATA_W-1:DONE_BIT+1] == '0
            && rd_data[RATE_LSB +: RATE_W] == $past(negotiated_fast_rate))
        else $error("status read wrong");

    chk_opt_cap_zero: assert property (@(posedge core_clk) // RULE18
        disable iff (rst || por_rst)
        rd_en && rd_addr == OFS_OPT_CAP |=> rd_data == RST_WORD)
        else $error("optional capability not all zero");

    chk_sel_low_legal: assert property (@(posedge core_clk) // RULE7
        disable iff (por_rst) fml_low_ok(fast_rate_sel_low))
        else $error("lower rate select holds reserved code");

    chk_sel_high_legal: assert property (@(posedge core_clk) // RULE9
        disable iff (por_rst) fml_high_ok(fast_rate_sel_high))
        else $error("upper rate select holds reserved code");

    chk_entry_pulse: assert property (@(posedge core_clk) // RULE14
        disable iff (rst || por_rst)
        wr_ctl && wr_data[ENA_BIT] && !s_q.ena && link_pcie_mode
        && link_speed == RATE_2G5 ##1 link_pcie_mode
        && link_speed == RATE_2G5 |=> fast_entry_go)
        else $error("entry request not forwarded");

    chk_sticky_kept: assert property (@(posedge core_clk) // RULE17
        disable iff (por_rst)
        rst && compliance_sticky_select
        |=> $stable(fast_rate_sel_low) && $stable(fast_rate_sel_high))
        else $error("sticky selects lost over warm reset");

    chk_plain_cleared: assert property (@(posedge core_clk) // RULE10
        disable iff (por_rst)
        rst && !compliance_sticky_select
        |=> fast_rate_sel_low == RST_RATE && !s_q.ena)
        else $error("plain control fields not cleared");

    // Status path follows the PHY; odd codes leave it alone
    chk_rate_follows: assert property (@(posedge core_clk) // RULE1
        disable iff (rst || por_rst)
        !rst && fml_stat_ok(phy_fast_rate)
        |=> negotiated_fast_rate == $past(phy_fast_rate))
        else $error("rate did not follow phy");

    chk_rate_rsvd_kept: assert property (@(posedge core_clk) // RULE2
        disable iff (rst || por_rst)
        !rst && !fml_stat_ok(phy_fast_rate)
        |=> $stable(negotiated_fast_rate))
        else $error("reserved rate code taken");

    chk_rdata_idle: assert property (@(posedge core_clk) // RULE20
        disable iff (rst || por_rst)
        !rd_en
        |=> rd_data == RST_WORD)
        else $error("read data without a read");

    // Calibration request and done flag
    chk_cal_request: assert property (@(posedge core_clk) // RULE11
        disable iff (rst || por_rst)
        !rst && wr_ctl && wr_data[CAL_BIT]
        |=> ctl.cal_req)
        else $error("calibration write gave no request");

    chk_cal_clears_done: assert property (@(posedge core_clk) // RULE4
        disable iff (rst || por_rst)
        wr_ctl && wr_data[CAL_BIT] && !ctl.cal_done
        |=> !calib_done_flag)
        else $error("done flag kept over new start");

    chk_done_held: assert property (@(posedge core_clk) // RULE4
        disable iff (rst || por_rst)
        !rst && calib_done_flag && !(wr_ctl && wr_data[CAL_BIT])
        |=> calib_done_flag)
        else $error("done flag dropped");

    // Entry only on a rising enable, only from base rates
    chk_entry_once: assert property (@(posedge core_clk) // RULE14
        disable iff (rst || por_rst)
        wr_ctl && wr_data[ENA_BIT] && s_q.ena
        |=> !ctl.ent_req)
        else $error("entry asked while enabled");

    chk_entry_gated: assert property (@(posedge core_clk) // RULE14
        disable iff (rst || por_rst)
        fast_entry_go |-> $past(ctl.ent_req) && $past(link_pcie_mode)
        && ($past(link_speed) == RATE_2G5 || $past(link_speed) == RATE_5G))
        else $error("entry pulse not gated");

    // Warm reset spares sticky state, power-on clears all
    chk_por_clears: assert property (@(posedge core_clk) // RULE22
        por_rst
        |=> s_q == RST_ALL)
        else $error("power-on reset left state");

    chk_comp_warm_kept: assert property (@(posedge core_clk) // RULE17
        disable iff (por_rst)
        rst && !wr_ctl
        |=> $stable(compliance_sticky_select))
        else $error("compliance bit lost");

    chk_sel_hi_cleared: assert property (@(posedge core_clk) // RULE10
        disable iff (por_rst)
        rst && !compliance_sticky_select
        |=> fast_rate_sel_high == RST_RATE)
        else $error("upper select not cleared");

    chk_seq_reset_plain: assert property (@(posedge core_clk) // RULE17
        disable iff (por_rst)
        rst && !compliance_sticky_select
        |=> !phy_cal_run)
        else $error("calibration kept over plain reset");
endmodule

/* common/fml_pkg.sv */
// Purpose: Shared constants and helpers for the fast link mode registers
// Assumes: 32-bit register words, byte offsets on an 8-bit address
// Notes:   Rate codes are the 7-bit encodings used by status and control
package fml_pkg;
    // Register map
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 32;
    localparam logic [7:0] OFS_OPT_CAP   = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_CONTROL   = 8'h08;

    // Field positions
    localparam int         RATE_LSB      = 0;
    localparam int         RATE_W        = 7;
    localparam int         DONE_BIT      = 7;
    localparam int         CAL_BIT       = 7;
    localparam int         SEL_HI_LSB    = 8;
    localparam int         ENA_BIT       = 15;
    localparam int         COMP_BIT      = 19;

    // Rate codes
    localparam logic [6:0] RATE_NONE     = 7'h00;
    localparam logic [6:0] RATE_2G5      = 7'h01;
    localparam logic [6:0] RATE_5G       = 7'h02;
    localparam logic [6:0] RATE_8G       = 7'h03;
    localparam logic [6:0] RATE_16G      = 7'h06;
    localparam logic [6:0] RATE_20G      = 7'h0a;
    localparam logic [6:0] RATE_25G      = 7'h0f;
    localparam logic [6:0] RATE_32G      = 7'h16;

    // Reset values
    localparam logic [6:0]  RST_RATE     = 7'h00;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;

    // Calibration sequencer states, Gray from idle through wait to run; run back to idle flips both bits
    typedef enum logic [1:0]
    {
        FML_CAL_IDLE = 2'b00,
        FML_CAL_WAIT = 2'b01,
        FML_CAL_RUN  = 2'b11
    } fml_cal_st_t;

    // Legal codes of the lower rate select field
    function automatic logic fml_low_ok(input logic [6:0] c);
        fml_low_ok = (c == RATE_NONE) || (c == RATE_8G) ||
                     (c == RATE_16G) || (c == RATE_20G) ||
                     (c == RATE_25G) || (c == RATE_32G);
    endfunction

    // Legal codes of the upper rate select field
    function automatic logic fml_high_ok(input logic [6:0] c);
        fml_high_ok = (c == RATE_NONE) || (c == RATE_16G) ||
                      (c == RATE_20G) || (c == RATE_32G);
    endfunction

    // Legal codes of the negotiated rate
    function automatic logic fml_stat_ok(input logic [6:0] c);
        fml_stat_ok = fml_low_ok(c) || (c == RATE_2G5) || (c == RATE_5G);
    endfunction
endpackage

/* common/fml_ctl_if.sv */
// Purpose: Carries requests and answers between register core and helpers
// Assumes: All signals on core_clk
// Notes:   Requests are one-cycle pulses
`timescale 1ns/1ns
interface fml_ctl_if;
    logic cal_req;
    logic cal_run;
    logic cal_done;
    logic ent_req;
    logic ent_go;

    modport core (output cal_req, output ent_req,
                  input cal_run, input cal_done, input ent_go);
    modport cal  (input cal_req, output cal_run, output cal_done);
    modport ent  (input ent_req, output ent_go);
endinterface

/* rtl/fml_cal_seq.sv */
// Purpose: Holds a calibration request until the link is parked, then runs
// Assumes: PHY inputs are on core_clk
// Notes:   Reset is kept off while sticky controls apply
`timescale 1ns/1ns
module fml_cal_seq
    import fml_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic seq_rst,
    input  wire logic link_in_l1,
    input  wire logic pm_non_d0,
    input  wire logic phy_cal_ack,
    fml_ctl_if.cal    ctl
);
    typedef struct packed
    {
        fml_cal_st_t st;
        logic        run;
        logic        done;
    } fml_cal_t;

    fml_cal_t s_q;
    fml_cal_t s_d;

    // Sequencer: wait for parked link, run, report done once
    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            FML_CAL_IDLE:
                if (ctl.cal_req)
                    s_d.st = FML_CAL_WAIT;
            FML_CAL_WAIT:
                if (link_in_l1 && pm_non_d0)
                begin
                    s_d.st  = FML_CAL_RUN; // RULE12
                    s_d.run = 1'b1;
                end
            FML_CAL_RUN:
                if (phy_cal_ack)
                begin
                    s_d.st   = FML_CAL_IDLE;
                    s_d.run  = 1'b0;
                    s_d.done = 1'b1; // RULE4
                end
            default:
                s_d.st = FML_CAL_IDLE;
        endcase
        if (seq_rst)
            s_d = '{st: FML_CAL_IDLE, run: 1'b0, done: 1'b0};
    end

    always_ff @(posedge core_clk)
        s_q <= s_d;

    assign ctl.cal_run  = s_q.run;
    assign ctl.cal_done = s_q.done;

    chk_cal_parked_link: assert property (@(posedge core_clk) // RULE12
        disable iff (seq_rst) $rose(s_q.run) |-> $past(link_in_l1 && pm_non_d0))
        else $error("calibration began outside parked link");
endmodule

/* rtl/fml_entry.sv */
// Purpose: Gates a fast mode entry request on the current link state
// Assumes: Link state inputs are on core_clk
// Notes:   Requests at other rates are dropped, the outcome is undefined
`timescale 1ns/1ns
module fml_entry
    import fml_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [6:0] link_speed,
    input  wire logic       link_pcie_mode,
    fml_ctl_if.ent          ctl
);
    typedef struct packed
    {
        logic go;
    } fml_ent_t;

    fml_ent_t s_q;
    fml_ent_t s_d;

    // Entry allowed only from the two base rates in PCIe mode
    always_comb
    begin
        s_d.go = ctl.ent_req && link_pcie_mode &&
                 (link_speed == RATE_2G5 || link_speed == RATE_5G); // RULE14
        if (rst)
            s_d.go = 1'b0;
    end

    always_ff @(posedge core_clk)
        s_q <= s_d;

    assign ctl.ent_go = s_q.go;
endmodule

/* sim/fml_phy_model.sv */
// Purpose: PHY and power state stand-in
// Assumes: All signals on core_clk
// Notes:   Ack is one pulse, ACK_DLY cycles into a run
`timescale 1ns/1ns
module fml_phy_model
#(
    parameter int ACK_DLY = 6
)
(
    input  wire logic core_clk,
    input  wire logic park,
    input  wire logic phy_cal_run,
    output logic      link_in_l1,
    output logic      pm_non_d0,
    output logic      phy_cal_ack = 1'b0
);
    int run_cnt = 0;
    // Parked link shows L1 and non-D0 together
    assign link_in_l1 = park;
    assign pm_non_d0  = park;
    // Slow finish, so a design that skips the wait is seen
    always @(posedge core_clk)
    begin
        run_cnt     <= (phy_cal_run === 1'b1) ? run_cnt + 1 : 0;
        phy_cal_ack <= (phy_cal_run === 1'b1) && (run_cnt == ACK_DLY);
    end
endmodule

/* sim/fml_regs_bench.sv */
// Purpose: Self-checking bench for the fast link mode registers
// Assumes: One core_clk domain at 25 MHz
// Notes:   PHY side from the partner model; fixed stimulus only
`timescale 1ns/1ns
module fml_regs_bench
    import fml_pkg::*;
;
    logic              core_clk;
    logic              rst;
    logic              por_rst;
    logic [ADDR_W-1:0] rd_addr;
    logic              rd_en;
    logic [ADDR_W-1:0] wr_addr;
    logic              wr_en;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] rd_data;
    logic [6:0]        phy_rate;
    logic [6:0]        link_speed;
    logic              pcie_mode;
    logic              in_l1;
    logic              non_d0;
    logic              cal_ack;
    logic              cal_run;
    logic              entry_go;
    logic [6:0]        sel_lo;
    logic [6:0]        sel_hi;
    logic [6:0]        neg_rate;
    logic              comp_sel;
    logic              done_flag;
    logic              park;
    logic [31:0]       v;
    logic [31:0]       w;
    int                fails = 0;
    int                compares = 0;
    int                cyc = 0;
    int                go_cnt = 0;
    localparam logic [6:0] STAT_C [8] = '{RATE_NONE, RATE_2G5, RATE_5G,
        RATE_8G, RATE_16G, RATE_20G, RATE_25G, RATE_32G};
    localparam logic [6:0] LOW_C [6] = '{RATE_NONE, RATE_8G, RATE_16G,
        RATE_20G, RATE_25G, RATE_32G};
    localparam logic [6:0] HIGH_C [4] = '{RATE_NONE, RATE_16G, RATE_20G,
        RATE_32G};
    localparam logic [6:0] SPD_C [3] = '{RATE_2G5, RATE_5G, RATE_2G5};

    fml_regs fml_regs_inst (
        .core_clk                 (core_clk),
        .rst                      (rst),
        .por_rst                  (por_rst),
        .rd_addr                  (rd_addr),
        .rd_en                    (rd_en),
        .wr_addr                  (wr_addr),
        .wr_en                    (wr_en),
        .wr_data                  (wr_data),
        .rd_data                  (rd_data),
        .phy_fast_rate            (phy_rate),
        .link_speed               (link_speed),
        .link_pcie_mode           (pcie_mode),
        .link_in_l1               (in_l1),
        .pm_non_d0                (non_d0),
        .phy_cal_ack              (cal_ack),
        .phy_cal_run              (cal_run),
        .fast_entry_go            (entry_go),
        .fast_rate_sel_low        (sel_lo),
        .fast_rate_sel_high       (sel_hi),
        .negotiated_fast_rate     (neg_rate),
        .calib_done_flag          (done_flag),
        .compliance_sticky_select (comp_sel)
    );
    fml_phy_model fml_phy_model_inst (
        .core_clk    (core_clk),
        .park        (park),
        .phy_cal_run (cal_run),
        .link_in_l1  (in_l1),
        .pm_non_d0   (non_d0),
        .phy_cal_ack (cal_ack)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Entry pulses counted, since each stands one cycle only
    always @(posedge core_clk)
    begin
        if (entry_go === 1'b1)
            go_cnt <= go_cnt + 1;
    end
    // Hang guard; whole run is well under a thousand cycles
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("Compares %0d, fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wr_en   <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge core_clk);
        wr_en   <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        rd_en   <= 1'b1;
        rd_addr <= a;
        @(posedge core_clk);
        rd_en   <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic pulse(input bit por);
        @(posedge core_clk);
        rst     <= !por;
        por_rst <= por;
        repeat (2) @(posedge core_clk);
        rst     <= 1'b0;
        por_rst <= 1'b0;
    endtask

    task automatic t_reset();
        rd(OFS_OPT_CAP, v);
        chk("opt_cap", v, RST_WORD);
        rd(OFS_STATUS, v);
        chk("status", v, RST_WORD);
        wr(8'h0c, 32'hffff_ffff);
        rd(8'h0c, v);
        chk("unmapped", v, RST_WORD);
        rd(OFS_CONTROL, v);
        chk("control", v, RST_WORD);
    endtask
    task automatic t_status();
        foreach (STAT_C[i])
        begin
            phy_rate <= STAT_C[i];
            rd(OFS_STATUS, v);
            chk("rate", v, {25'h0, STAT_C[i]});
            chk("rate_pin", {25'h0, neg_rate}, {25'h0, STAT_C[i]});
        end
        phy_rate <= 7'h05;
        rd(OFS_STATUS, v);
        chk("rate_rsvd", v, {25'h0, RATE_32G});
    endtask
    task automatic t_select();
        foreach (LOW_C[i])
        begin
            w = {17'h0, HIGH_C[i % 4], 1'b0, LOW_C[i]};
            wr(OFS_CONTROL, w);
            rd(OFS_CONTROL, v);
            chk("sel", v, w);
        end
        chk("sel_low_pin", {25'h0, sel_lo}, {25'h0, RATE_32G});
        chk("sel_high_pin", {25'h0, sel_hi}, {25'h0, RATE_16G});
        // Reserved codes in both fields are dropped
        wr(OFS_CONTROL, 32'h0000_0305);
        rd(OFS_CONTROL, v);
        chk("sel_rsvd", v, {17'h0, RATE_16G, 1'b0, RATE_32G});
    endtask
    task automatic t_calib();
        park <= 1'b0;
        wr(OFS_CONTROL, 32'h0000_0080);
        rd(OFS_CONTROL, v);
        chk("cal_read", v, RST_WORD);
        repeat (10) @(posedge core_clk);
        #1 chk("cal_held", {31'h0, cal_run}, 32'h0);
        rd(OFS_STATUS, v);
        chk("done_early", v, {25'h0, RATE_32G});
        park <= 1'b1;
        for (int k = 0; k < 40 && done_flag !== 1'b1; k++)
            @(posedge core_clk);
        rd(OFS_STATUS, v);
        chk("cal_done", v, {24'h0, 1'b1, RATE_32G});
        chk("cal_stop", {31'h0, cal_run}, 32'h0);
    endtask
    // Entry only ever asked at base rates in PCIe mode
    task automatic t_entry();
        pcie_mode <= 1'b1;
        foreach (SPD_C[i])
        begin
            link_speed <= SPD_C[i];
            wr(OFS_CONTROL, RST_WORD);
            wr(OFS_CONTROL, 32'h0000_8000);
            wr(OFS_CONTROL, 32'h0000_8000);
            repeat (4) @(posedge core_clk);
            chk("entry_go", go_cnt, i + 1);
            rd(OFS_CONTROL, v);
            chk("entry_bit", v, 32'h0000_8000);
        end
    endtask
    task automatic t_sticky();
        wr(OFS_CONTROL, 32'h0008_0603);
        pulse(1'b0);
        rd(OFS_CONTROL, v);
        chk("sticky_warm", v, 32'h0008_0603);
        chk("comp_warm", {31'h0, comp_sel}, 32'h1);
        pulse(1'b1);
        rd(OFS_CONTROL, v);
        chk("sticky_por", v, RST_WORD);
        chk("comp_por", {31'h0, comp_sel}, 32'h0);
        wr(OFS_CONTROL, 32'h0000_0603);
        pulse(1'b0);
        rd(OFS_CONTROL, v);
        chk("plain_warm", v, RST_WORD);
    endtask

    initial
    begin
        rst        = 1'b1;
        por_rst    = 1'b1;
        rd_en      = 1'b0;
        wr_en      = 1'b0;
        rd_addr    = 8'h00;
        wr_addr    = 8'h00;
        wr_data    = 32'h0;
        phy_rate   = RATE_NONE;
        link_speed = RATE_2G5;
        pcie_mode  = 1'b0;
        park       = 1'b0;
        repeat (20) @(posedge core_clk);
        rst     <= 1'b0;
        por_rst <= 1'b0;
        t_reset();
        t_status();
        t_select();
        t_calib();
        t_entry();
        t_sticky();
        end_of_test();
    end
endmodule
